// ---- core/switch_register_page.sv ----
// Register page and identity ROM of the eight-channel addressable switch
`timescale 1ns/1ns
`include "switch_page_regs.svh"
module switch_register_page #(
	parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
	parameter logic [47:0] SERIAL_NUMBER = 48'h0123_4567_89ab // Arbitrary value
) (
	input wire logic clk_i, // Clock, 10 MHz
	input wire logic reset_n_i, // Power-on reset, active low
	input wire logic [7:0] channel_pin_i, // Channel pin levels
	input wire logic supply_present_i, // External supply connected
	input wire logic dual_function_pin_i, // Dual-function pin level
	output logic dual_function_pin_o, // Open-drain drive, always low
	output logic dual_function_pin_oe_n_o, // Low while pulling the pin low
	output logic [7:0] channel_drive_o, // Output latch, 1 = transistor off
	input wire logic [15:0] reg_addr_i, // Register read address
	input wire logic sample_i, // Sample pins (MS bit of prior byte)
	input wire logic read_i, // Register read strobe
	output logic [7:0] read_data_o, // Register read data
	input wire logic search_write_i, // Write search registers command
	input wire logic [7:0] wr_mask_i, // New mask value
	input wire logic [7:0] wr_polarity_i, // New polarity value
	input wire logic [7:0] wr_ctrl_i, // New control value
	input wire logic channel_write_i, // Channel-access write command
	input wire logic [7:0] channel_data_i, // Channel-access write data
	input wire logic channel_access_done_i, // Channel-access transfer done
	input wire logic reset_latches_i, // Reset-activity-latches done
	input wire logic reinit_i, // Self reinitialisation after ESD
	output logic search_answer_o, // Device answers conditional search
	output logic [63:0] identity_o, // Identity code, family in low byte
	output logic identity_ready_o, // Identity CRC computed
	output logic [7:0] pin_function_o // Control register image
);
	logic [7:0] pin_levels;
	logic [7:0] out_latch;
	logic [7:0] chg_latch;
	logic [7:0] mask;
	logic [7:0] polarity;
	logic [3:0] ctrl_cfg;
	logic [7:0] ctrl_image;
	logic [7:0] crc;
	logic [5:0] bit_idx;
	logic [55:0] id_body;
	logic crc_clear;
	logic crc_shift;
	logic pin_reset;
	logic [3:0] pulse_cnt;
	logic [7:0] src;
	logic [7:0] match;
	logic any_hit;
	logic all_hit;
	switch_page_pkg::crc_state_t crc_state;

	assign id_body = {SERIAL_NUMBER, FAMILY_CODE};
	assign pin_reset = !ctrl_cfg[`CTRL_PIN_FUNC_BIT] && !dual_function_pin_i;

	// CRC is built after reset from the body, LSB of family first
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			crc_state <= switch_page_pkg::CRC_IDLE;
			bit_idx <= 6'h00;
		end
		else
		begin
			unique case (crc_state)
				switch_page_pkg::CRC_IDLE:
				begin
					crc_state <= switch_page_pkg::CRC_RUN;
					bit_idx <= 6'h00;
				end
				switch_page_pkg::CRC_RUN:
				begin
					// Index parks on the last body bit so it never points past the body
					if (bit_idx == 6'h37)
						crc_state <= switch_page_pkg::CRC_DONE;
					else
						bit_idx <= bit_idx + 6'h01;
				end
				switch_page_pkg::CRC_DONE:
					crc_state <= switch_page_pkg::CRC_DONE;
			endcase
		end
	end

	assign crc_clear = crc_state == switch_page_pkg::CRC_IDLE;
	assign crc_shift = crc_state == switch_page_pkg::CRC_RUN;

	identity_crc u_crc (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.clear_i(crc_clear),
		.shift_i(crc_shift),
		.bit_i(id_body[bit_idx]),
		.crc_o(crc)
	);

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			identity_o <= 64'h0;
		else if (crc_state == switch_page_pkg::CRC_DONE)
			identity_o <= {crc, id_body};
	end

	// Ready rises on the same edge that loads the identity, never ahead of it
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			identity_ready_o <= 1'b0;
		else if (crc_state == switch_page_pkg::CRC_DONE)
			identity_ready_o <= 1'b1;
	end

	// Pin levels are caught only on the sample strobe, not on each read
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			pin_levels <= 8'h00;
		else if (sample_i)
			pin_levels <= channel_pin_i;
	end

	// Output latch has no reset term: it powers up arbitrary and survives reinit
	always_ff @(posedge clk_i)
	begin
		if (pin_reset)
			out_latch <= 8'hff;
		else if (channel_write_i)
			out_latch <= channel_data_i;
	end

	assign channel_drive_o = out_latch;

	change_latch_bank u_chg (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.pins_i(channel_pin_i),
		.clear_i(pin_reset || reset_latches_i),
		.latch_o(chg_latch)
	);

	// Search registers: reset values only, changed only by their command
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			mask <= `SEARCH_RESET;
			polarity <= `SEARCH_RESET;
		end
		else if (search_write_i)
		begin
			mask <= wr_mask_i;
			polarity <= wr_polarity_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			ctrl_cfg <= 4'(`CTRL_RESET);
		else if (search_write_i)
			ctrl_cfg <= wr_ctrl_i[3:0] & 4'(`CTRL_WRITE_MASK);
	end

	assign ctrl_image = {supply_present_i, 3'b000, ctrl_cfg};
	assign pin_function_o = ctrl_image;

	assign src = ctrl_cfg[`CTRL_SOURCE_BIT] ? chg_latch : channel_pin_i;
	assign match = ~(src ^ polarity);
	assign any_hit = |(match & mask);
	assign all_hit = &(match | ~mask);

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			search_answer_o <= 1'b1;
		else
			search_answer_o <= ctrl_cfg[`CTRL_POWER_UP_BIT]
				|| (ctrl_cfg[`CTRL_COMBINE_BIT] ? all_hit : any_hit);
	end

	// Register reads never touch the pulse counter
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			read_data_o <= `UNDEF_BYTE;
		else if (read_i)
		begin
			unique case (reg_addr_i)
				`ADDR_PIN_LEVELS: read_data_o <= pin_levels;
				`ADDR_OUT_LATCHES: read_data_o <= out_latch;
				`ADDR_CHG_LATCHES: read_data_o <= chg_latch;
				`ADDR_MASK: read_data_o <= mask;
				`ADDR_POLARITY: read_data_o <= polarity;
				`ADDR_CTRL: read_data_o <= ctrl_image;
				`ADDR_FILL_LO, `ADDR_FILL_HI: read_data_o <= `FILL_BYTE;
				default: read_data_o <= `UNDEF_BYTE;
			endcase
		end
	end

	// Transfer pulse only after channel-access transfers, in pulse-output mode
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			pulse_cnt <= 4'h0;
		else if (channel_access_done_i && ctrl_cfg[`CTRL_PIN_FUNC_BIT])
			pulse_cnt <= 4'(`PULSE_CYCLES);
		else if (pulse_cnt != 4'h0)
			pulse_cnt <= pulse_cnt - 4'h1;
	end

	assign dual_function_pin_o = 1'b0;
	assign dual_function_pin_oe_n_o = !(pulse_cnt != 4'h0 && ctrl_cfg[`CTRL_PIN_FUNC_BIT]);

	logic unused_reinit;
	assign unused_reinit = reinit_i; // Reinit deliberately leaves the output latch alone
endmodule : switch_register_page

// ---- core/switch_page_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the switch register page
// Functional notes
// - Hold 64-bit identity: family, serial, CRC
// - Identity CRC polynomial x^8+x^5+x^4+1
// - CRC cleared, family LSB first, then serial
// - Page registers volatile; all but output latch reset-defined
// - 008Eh/008Fh read FFh; low addresses undefined
// - Pin-state register samples pins before reading
// - Register reads never pulse dual-function pin
// - Output latch holds channel write across reinit
// - Latch arbitrary at power-up; pin low sets
// - Change latches clear on reset, pin, command
// - Mask bit includes channel; clears on reset
// - Polarity per channel, source by bit 0
// - Search registers written only by their command
// - Control bits 4..6 read zero always
// - Control reads 08h after reset unsupplied
// - Bit 0 selects pins or change latches
// - Bit 1 selects OR or AND combine
// - Bit 2 selects reset input or pulse output
// - Power-up flag set by reset, answers search
`ifndef SWITCH_PAGE_REGS_SVH
`define SWITCH_PAGE_REGS_SVH
`define ADDR_PIN_LEVELS 16'h0088
`define ADDR_OUT_LATCHES 16'h0089
`define ADDR_CHG_LATCHES 16'h008a
`define ADDR_MASK 16'h008b
`define ADDR_POLARITY 16'h008c
`define ADDR_CTRL 16'h008d
`define ADDR_FILL_LO 16'h008e
`define ADDR_FILL_HI 16'h008f
`define FILL_BYTE 8'hff
`define UNDEF_BYTE 8'h00
`define CTRL_SOURCE_BIT 0
`define CTRL_COMBINE_BIT 1
`define CTRL_PIN_FUNC_BIT 2
`define CTRL_POWER_UP_BIT 3
`define CTRL_SUPPLY_BIT 7
`define CTRL_WRITE_MASK 8'h0f
`define CTRL_RESET 8'h08
`define SEARCH_RESET 8'h00
`define CHG_RESET 8'h00
`define CRC_POLY 8'h8c
`define CRC_INIT 8'h00
`define PULSE_NS 1000
`define CLK_NS 100
`define PULSE_CYCLES ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ---- core/switch_page_pkg.sv ----
// Types shared by the switch register page
package switch_page_pkg;
	typedef enum logic [1:0] {CRC_IDLE, CRC_RUN, CRC_DONE} crc_state_t;
	typedef logic [7:0] byte_t;
endpackage : switch_page_pkg

// ---- core/identity_crc.sv ----
// Serial CRC8 generator for the identity code
`timescale 1ns/1ns
`include "switch_page_regs.svh"
module identity_crc (
	input wire logic clk_i, // Clock
	input wire logic reset_n_i, // Synchronous reset, active low
	input wire logic clear_i, // Clear shift register
	input wire logic shift_i, // Shift one bit
	input wire logic bit_i, // Data bit, LSB first
	output logic [7:0] crc_o // Shift register contents
);
	logic fb;

	assign fb = crc_o[0] ^ bit_i;
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i || clear_i)
			crc_o <= `CRC_INIT;
		else if (shift_i)
			crc_o <= (crc_o >> 1) ^ (fb ? `CRC_POLY : 8'h00);
	end
endmodule : identity_crc

// ---- core/change_latch_bank.sv ----
// Activity latches that catch any pin change until cleared
`timescale 1ns/1ns
`include "switch_page_regs.svh"
module change_latch_bank (
	input wire logic clk_i, // Clock
	input wire logic reset_n_i, // Synchronous reset, active low
	input wire logic [7:0] pins_i, // Channel pin levels
	input wire logic clear_i, // Clear all latches
	output logic [7:0] latch_o // Latched change flags
);
	logic [7:0] prev;

	always_ff @(posedge clk_i)
	begin
		prev <= pins_i;
	end

	// Set beats clear so an edge in the clearing cycle is kept
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			latch_o <= `CHG_RESET;
		else
			latch_o <= (clear_i ? 8'h00 : latch_o) | (pins_i ^ prev);
	end
endmodule : change_latch_bank

// ---- tb/switch_register_page_props.sv ----
// Port checker for the switch register page
`timescale 1ns/1ns
module switch_register_page_props (
	input wire logic clk_i, // Clock
	input wire logic reset_n_i, // Reset
	input wire logic dual_function_pin_i, // Pin level
	input wire logic channel_access_done_i, // Done
	input wire logic channel_write_i, // Write
	input wire logic [7:0] channel_data_i, // Data
	input wire logic read_i, // Read
	input wire logic [15:0] reg_addr_i, // Address
	input wire logic [7:0] read_data_o, // Read data
	input wire logic search_write_i, // Search write
	input wire logic [7:0] wr_ctrl_i, // New control
	input wire logic [7:0] pin_function_o, // Control image
	input wire logic [7:0] channel_drive_o, // Latch
	input wire logic dual_function_pin_oe_n_o, // Pin enable
	input wire logic search_answer_o // Answer
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	chk_fill_reads_ff: assert property (read_i && reg_addr_i[15:1] == 15'h0047
		|=> read_data_o == 8'hff) else $error("fill byte wrong");
	chk_ctrl_zero_bits: assert property (pin_function_o[6:4] == 3'h0)
		else $error("control bits 6..4 set");
	chk_ctrl_after_rst: assert property ($rose(reset_n_i) |-> pin_function_o[6:0] == 7'h08)
		else $error("control reset value wrong");
	chk_ctrl_write: assert property (search_write_i
		|=> pin_function_o[3:0] == $past(wr_ctrl_i[3:0])) else $error("control not written");
	chk_pin_rst_sets: assert property (!pin_function_o[2] && !dual_function_pin_i
		|=> channel_drive_o == 8'hff) else $error("pin reset missed");
	chk_chan_write: assert property (channel_write_i && dual_function_pin_i
		|=> channel_drive_o == $past(channel_data_i)) else $error("latch not written");
	chk_read_no_strobe: assert property (read_i && !channel_access_done_i
		&& dual_function_pin_oe_n_o |=> dual_function_pin_oe_n_o) else $error("read pulsed pin");
	chk_strobe_len: assert property ($fell(dual_function_pin_oe_n_o) |->
		!dual_function_pin_oe_n_o[*8] ##1 !dual_function_pin_oe_n_o ##1 !dual_function_pin_oe_n_o
		##1 dual_function_pin_oe_n_o) else $error("strobe width wrong");
	chk_powerup_answer: assert property (pin_function_o[3] |=> search_answer_o)
		else $error("power-up flag ignored");
endmodule : switch_register_page_props
bind switch_register_page switch_register_page_props u_props (.clk_i(clk_i),
	.reset_n_i(reset_n_i), .dual_function_pin_i(dual_function_pin_i),
	.channel_access_done_i(channel_access_done_i), .channel_write_i(channel_write_i),
	.channel_data_i(channel_data_i), .read_i(read_i), .reg_addr_i(reg_addr_i),
	.read_data_o(read_data_o), .search_write_i(search_write_i), .wr_ctrl_i(wr_ctrl_i),
	.pin_function_o(pin_function_o), .channel_drive_o(channel_drive_o),
	.dual_function_pin_oe_n_o(dual_function_pin_oe_n_o), .search_answer_o(search_answer_o));

// ---- tb/link_master_model.sv ----
// Link master model: register reads, pin samples, search register writes
`timescale 1ns/1ns
module link_master_model (
	input wire logic clk_i, // Clock
	input wire logic [7:0] read_data_i, // Read data
	output logic [15:0] reg_addr_o, // Address
	output logic read_o, // Read strobe
	output logic sample_o, // Sample strobe
	output logic search_write_o, // Write strobe
	output logic [7:0] mask_o, // Mask
	output logic [7:0] polarity_o, // Polarity
	output logic [7:0] ctrl_o // Control
);
	initial
	begin
		{reg_addr_o, read_o, sample_o, search_write_o} = 19'h0;
		{mask_o, polarity_o, ctrl_o} = 24'h0;
	end
	// Sample during the byte before the first data byte
	task automatic read_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		sample_o = a == 16'h0088;
		@(posedge clk_i);
		#1;
		{sample_o, read_o, reg_addr_o} = {2'b01, a};
		@(posedge clk_i);
		#1;
		{read_o, reg_addr_o} = {1'b0, ~a};
		d = read_data_i;
	endtask : read_reg
	// Released fields show inverted data so stale values are not trusted
	task automatic write_search(input logic [7:0] m, input logic [7:0] p, input logic [7:0] c);
		@(posedge clk_i);
		#1;
		{search_write_o, mask_o, polarity_o, ctrl_o} = {1'b1, m, p, c};
		@(posedge clk_i);
		#1;
		{search_write_o, mask_o, polarity_o, ctrl_o} = {1'b0, ~m, ~p, ~c};
	endtask : write_search
endmodule : link_master_model

// ---- tb/tb_switch_register_page.sv ----
// Self-checking bench for the switch register page
`timescale 1ns/1ns
module tb_switch_register_page;
	localparam logic [7:0] FAM = 8'h5a; // Arbitrary value
	localparam logic [47:0] SER = 48'h0123_4567_89ab; // Arbitrary value
	logic clk_i = 0, reset_n_i = 0, ext_n = 1, cw = 0, done = 0, clr = 0, reinit = 0;
	logic [7:0] pins = 8'h00, cd = 8'h00, got, rdata, m, p, c, drive, pfn;
	logic [15:0] addr;
	logic rd, smp, swr, oe_n, pin_o, answer, ready;
	logic [63:0] ident;
	wire dual = ext_n & (oe_n | pin_o);
	int fail_count = 0;
	int compares = 0;
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	switch_register_page #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER)) u_dut (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .channel_pin_i(pins), .supply_present_i(1'b0),
		.dual_function_pin_i(dual), .dual_function_pin_o(pin_o),
		.dual_function_pin_oe_n_o(oe_n), .channel_drive_o(drive), .reg_addr_i(addr),
		.sample_i(smp), .read_i(rd), .read_data_o(rdata), .search_write_i(swr),
		.wr_mask_i(m), .wr_polarity_i(p), .wr_ctrl_i(c), .channel_write_i(cw),
		.channel_data_i(cd), .channel_access_done_i(done), .reset_latches_i(clr),
		.reinit_i(reinit), .search_answer_o(answer), .identity_o(ident),
		.identity_ready_o(ready), .pin_function_o(pfn));
	link_master_model u_master (.clk_i(clk_i), .read_data_i(rdata), .reg_addr_o(addr),
		.read_o(rd), .sample_o(smp), .search_write_o(swr), .mask_o(m), .polarity_o(p),
		.ctrl_o(c));
	task automatic end_of_test;
		if (fail_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [63:0] g, input logic [63:0] e);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : check
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		u_master.read_reg(a, got);
		check(got, e);
	endtask : rd_chk
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	task automatic t_reset_values;
		int i;
		logic [55:0] raw;
		logic [7:0] crc;
		raw = {SER, FAM};
		crc = 8'h00;
		for (i = 0; i < 56; i++)
			crc = (crc >> 1) ^ ((crc[0] ^ raw[i]) ? 8'h8c : 8'h00);
		for (i = 0; i < 200 && ready !== 1'b1; i++)
			step(1);
		check(ready, 1'b1);
		check(ident, {crc, SER, FAM});
		for (i = 56; i < 64; i++)
			crc = (crc >> 1) ^ ((crc[0] ^ ident[i]) ? 8'h8c : 8'h00);
		check(crc, 8'h00);
		check(answer, 1'b1);
		rd_chk(16'h008d, 8'h08);
		rd_chk(16'h008b, 8'h00);
		rd_chk(16'h008c, 8'h00);
		rd_chk(16'h008a, 8'h00);
		rd_chk(16'h008e, 8'hff);
		rd_chk(16'h008f, 8'hff);
		rd_chk(16'h0087, 8'h00);
	endtask : t_reset_values
	task automatic t_search;
		u_master.write_search(8'h03, 8'h03, 8'hf3);
		rd_chk(16'h008d, 8'h03);
		check(answer, 1'b0);
		u_master.write_search(8'h03, 8'h03, 8'h00);
		pins = 8'h01;
		step(2);
		check(answer, 1'b1);
		u_master.write_search(8'h03, 8'h03, 8'h02);
		step(2);
		check(answer, 1'b0);
		u_master.write_search(8'h03, 8'h03, 8'h01);
		step(2);
		check(answer, 1'b1);
		rd_chk(16'h008b, 8'h03);
		rd_chk(16'h008c, 8'h03);
	endtask : t_search
	task automatic t_latches;
		rd_chk(16'h008a, 8'h01);
		clr = 1;
		step(1);
		clr = 0;
		rd_chk(16'h008a, 8'h00);
		pins = 8'h80;
		step(2);
		rd_chk(16'h008a, 8'h81);
		rd_chk(16'h0088, 8'h80);
	endtask : t_latches
	task automatic t_outputs;
		{cw, cd} = 9'h15a;
		step(1);
		cw = 0;
		check(drive, 8'h5a);
		rd_chk(16'h0089, 8'h5a);
		reinit = 1;
		step(1);
		reinit = 0;
		check(drive, 8'h5a);
		ext_n = 0;
		step(1);
		ext_n = 1;
		step(1);
		check(drive, 8'hff);
		rd_chk(16'h008a, 8'h00);
	endtask : t_outputs
	task automatic t_strobe;
		int i;
		int n;
		n = 0;
		u_master.write_search(8'h00, 8'h00, 8'h04);
		rd_chk(16'h0089, 8'hff);
		check(oe_n, 1'b1);
		done = 1;
		step(1);
		done = 0;
		for (i = 0; i < 20; i++)
		begin
			n += (oe_n === 1'b0);
			step(1);
		end
		check(n, 10);
		u_master.write_search(8'h00, 8'h00, 8'h00);
	endtask : t_strobe
	initial
	begin
		step(10);
		reset_n_i = 1;
		t_reset_values();
		t_search();
		t_latches();
		t_outputs();
		t_strobe();
		end_of_test();
	end
endmodule : tb_switch_register_page
